// ### hdl/sbcw_map.vh
// Purpose: Shared constants for the wake-up and serial mode timing block
// Assumes: 200 MHz ref_clk; times given in microseconds unless named
// Notes:   Cycle counts are derived from the printed figures
`ifndef SBCW_MAP_VH
`define SBCW_MAP_VH

// ********************************
// Clock
// ********************************
`define SBCW_CLK_MHZ        200

// ********************************
// Times and derived cycle counts
// ********************************
`define SBCW_T_CAN_MAX_US   10
// Apply at half the longest allowed delay, leaving margin for sync lag
`define SBCW_CAN_CYC        ((`SBCW_T_CAN_MAX_US * `SBCW_CLK_MHZ) / 2)
`define SBCW_T_CSWAKE_US    40
`define SBCW_CSWAKE_CYC     (`SBCW_T_CSWAKE_US * `SBCW_CLK_MHZ)
`define SBCW_T_RST_MS       15
`define SBCW_RST_CYC        (`SBCW_T_RST_MS * 1000 * `SBCW_CLK_MHZ)
`define SBCW_T_RSTS_US      3500
`define SBCW_RSTS_CYC       (`SBCW_T_RSTS_US * `SBCW_CLK_MHZ)
`define SBCW_T_OC_US        55
`define SBCW_OC_CYC         (`SBCW_T_OC_US * `SBCW_CLK_MHZ)
`define SBCW_T_WUF_US       20
`define SBCW_WUF_CYC        (`SBCW_T_WUF_US * `SBCW_CLK_MHZ)
`define SBCW_T_INT_US       10
`define SBCW_INT_CYC        (`SBCW_T_INT_US * `SBCW_CLK_MHZ)

// ********************************
// Modes
// ********************************
`define SBCW_MODE_RST       2'h0
`define SBCW_MODE_RUN       2'h1
`define SBCW_MODE_STOP      2'h2
`define SBCW_MODE_WAKE      2'h3

// ********************************
// Command byte layout
// ********************************
`define SBCW_FRAME_BITS     4'h8
`define SBCW_OP_HI          7
`define SBCW_OP_LO          4
`define SBCW_OP_CAN_NORM    4'h1
`define SBCW_OP_CAN_SLEEP   4'h2
`define SBCW_OP_SLEW        4'h3
`define SBCW_OP_STOP        4'h4
`define SBCW_SLEW_HI        1
`define SBCW_SLEW_LO        0
`define SBCW_SLEW_RST       2'h3

`endif

// ### hdl/sbcw_top.v
// Purpose: Mode timing, wake-up filtering and serial command port
// Assumes: All pins are asynchronous to ref_clk; sclk far below ref_clk
// Notes:   Serial frame is 8 bits, MSB first, command in the upper nibble
// Notes on behaviour
// - Transceiver normal within 10 us of bit 8
// - Transceiver sleep within 10 us of bit 8
// - Chip select rise in stop wakes, 15-90us
// - Reset held 12-18 ms, short variant 3.5 ms
// - Overcurrent wakes after 40-75 us deglitch
// - Wake inputs filtered 8-38 us before accepted
// - Input bits sampled on serial clock fall
// - Output bit changes on serial clock rise
// - Four slew settings, 3 fastest, 0 slowest
// - Serial port responds only while select low
// - Stop-mode wake by wake input or overcurrent gives 10 us low interrupt
`timescale 1ns/1ps
`include "sbcw_map.vh"

module sbcw_top #(
  parameter        SHORT_RST   = 0,
  parameter [13:0] CSWAKE_CYC  = `SBCW_CSWAKE_CYC,
  parameter [21:0] RST_CYC     = `SBCW_RST_CYC,
  parameter [21:0] RSTS_CYC    = `SBCW_RSTS_CYC,
  parameter [13:0] OC_CYC      = `SBCW_OC_CYC
) (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       mosi,
  output reg        miso,
  output wire       miso_oe,
  input  wire       vdd_ok,
  input  wire       vdd_oc,
  input  wire       wake_input_0,
  input  wire       wake_input_1,
  input  wire       wake_input_2,
  input  wire       wake_input_3,
  output reg        rst_n,
  output reg        int_n,
  output reg  [1:0] mode,
  output reg        can_normal,
  output reg  [1:0] slew
);

  localparam [1:0]  MODE_RST  = `SBCW_MODE_RST;
  localparam [1:0]  MODE_RUN  = `SBCW_MODE_RUN;
  localparam [1:0]  MODE_STOP = `SBCW_MODE_STOP;
  localparam [1:0]  MODE_WAKE = `SBCW_MODE_WAKE;
  localparam [10:0] CAN_CYC   = `SBCW_CAN_CYC;
  localparam [11:0] WUF_CYC   = `SBCW_WUF_CYC;
  localparam [10:0] INT_CYC   = `SBCW_INT_CYC;
  localparam [21:0] RST_LIM   = (SHORT_RST != 0) ? RSTS_CYC : RST_CYC;

  // ********************************
  // Pin synchronisers
  // ********************************
  reg  [7:0] meta;
  reg  [7:0] sync;
  reg        sclk_d;
  reg        cs_d;
  wire [3:0] wake_s;
  wire       sclk_s;
  wire       cs_s;
  wire       mosi_s;
  wire       vdd_ok_s;
  wire       vdd_oc_s;

  reg        mosi_m;
  reg        mosi_q;

  // Supply reads low until sampled, so no reset count starts early
  always @(posedge ref_clk) begin
    if (!nrst) begin
      meta   <= 8'h02;
      sync   <= 8'h02;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      meta   <= {wake_input_3, wake_input_2, wake_input_1, wake_input_0,
                 vdd_oc, vdd_ok, cs_n, sclk};
      sync   <= meta;
      sclk_d <= sync[0];
      cs_d   <= sync[1];
    end
  end

  assign sclk_s   = sync[0];
  assign cs_s     = sync[1];
  assign vdd_ok_s = sync[2];
  assign vdd_oc_s = sync[3];
  assign wake_s   = sync[7:4];
  assign mosi_s   = mosi_q;

  // Data line resynchronised on its own pair
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mosi_m <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      mosi_m <= mosi;
      mosi_q <= mosi_m;
    end
  end

  wire sel      = !cs_s;
  wire sclk_fall = sel && sclk_d && !sclk_s;
  wire sclk_rise = sel && !sclk_d && sclk_s;
  wire cs_fall   = cs_d && !cs_s;
  wire cs_rise   = !cs_d && cs_s;

  // ********************************
  // Wake input filters
  // ********************************
  wire [3:0] wake_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_wuf
      reg [11:0] cnt;
      reg        level;
      reg        hit;
      always @(posedge ref_clk) begin
        if (!nrst) begin
          cnt   <= 12'h000;
          level <= 1'b0;
          hit   <= 1'b0;
        end else begin
          hit <= 1'b0;
          if (wake_s[gi] == level) begin
            cnt <= 12'h000;
          end else if (cnt == WUF_CYC - 12'h001) begin
            // Level must stay changed for the whole window
            cnt   <= 12'h000;
            level <= wake_s[gi];
            hit   <= 1'b1;
          end else begin
            cnt <= cnt + 12'h001;
          end
        end
      end
      assign wake_hit[gi] = hit;
    end
  endgenerate

  // ********************************
  // Overcurrent deglitch
  // ********************************
  reg [13:0] oc_cnt;
  reg        oc_hit;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      oc_cnt <= 14'h0000;
      oc_hit <= 1'b0;
    end else begin
      oc_hit <= 1'b0;
      if (!vdd_oc_s) begin
        oc_cnt <= 14'h0000;
      end else if (oc_cnt == OC_CYC - 14'h0001) begin
        oc_cnt <= oc_cnt + 14'h0001;
        oc_hit <= 1'b1;
      end else if (oc_cnt < OC_CYC) begin
        oc_cnt <= oc_cnt + 14'h0001;
      end
    end
  end

  // ********************************
  // Serial port
  // ********************************
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  reg [3:0] bit_cnt;
  reg       cmd_stb;
  wire [7:0] status = {mode, can_normal, slew, rst_n, oc_cnt == OC_CYC,
                       |wake_s};

  assign miso_oe = sel;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      rx_sh   <= 8'h00;
      tx_sh   <= 8'h00;
      bit_cnt <= 4'h0;
      cmd_stb <= 1'b0;
      miso    <= 1'b0;
    end else begin
      cmd_stb <= 1'b0;
      if (cs_fall) begin
        bit_cnt <= 4'h0;
        tx_sh   <= {status[6:0], 1'b0};
        miso    <= status[7];
      end else if (sclk_fall) begin
        rx_sh   <= {rx_sh[6:0], mosi_s};
        bit_cnt <= bit_cnt + 4'h1;
        // Eighth falling edge starts every command delay
        cmd_stb <= (bit_cnt == `SBCW_FRAME_BITS - 4'h1);
      end else if (sclk_rise && bit_cnt != 4'h0) begin
        miso  <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // ********************************
  // Mode control and timers
  // ********************************
  wire [3:0] opcode = rx_sh[`SBCW_OP_HI:`SBCW_OP_LO];
  wire       run    = mode == MODE_RUN;
  wire       stop_wake = (mode == MODE_STOP) && (oc_hit || |wake_hit);

  reg [21:0] rst_cnt;
  reg [13:0] wk_cnt;
  reg [10:0] int_cnt;
  reg [10:0] can_cnt;
  reg        can_pend;
  reg        can_tgt;
  reg        stop_arm;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      mode       <= MODE_RST;
      rst_n      <= 1'b0;
      rst_cnt    <= 22'h000000;
      wk_cnt     <= 14'h0000;
      int_n      <= 1'b1;
      int_cnt    <= 11'h000;
      can_cnt    <= 11'h000;
      can_pend   <= 1'b0;
      can_tgt    <= 1'b0;
      stop_arm   <= 1'b0;
      can_normal <= 1'b0;
      slew       <= `SBCW_SLEW_RST;
    end else begin
      if (!int_n) begin
        if (int_cnt == INT_CYC - 11'h001) begin
          int_n <= 1'b1;
        end
        int_cnt <= int_cnt + 11'h001;
      end
      if (can_pend) begin
        if (can_cnt == CAN_CYC - 11'h001) begin
          can_pend   <= 1'b0;
          can_normal <= can_tgt;
        end
        can_cnt <= can_cnt + 11'h001;
      end
      if (!vdd_ok_s) begin
        mode    <= MODE_RST;
        rst_n   <= 1'b0;
        rst_cnt <= 22'h000000;
      end else begin
        case (mode)
          MODE_RST: begin
            if (rst_cnt == RST_LIM - 22'h000001) begin
              rst_n <= 1'b1;
              mode  <= MODE_RUN;
            end
            rst_cnt <= rst_cnt + 22'h000001;
          end
          MODE_RUN: begin
            if (cmd_stb) begin
              case (opcode)
                `SBCW_OP_CAN_NORM: begin
                  can_pend <= 1'b1;
                  can_tgt  <= 1'b1;
                  can_cnt  <= 11'h000;
                end
                `SBCW_OP_CAN_SLEEP: begin
                  can_pend <= 1'b1;
                  can_tgt  <= 1'b0;
                  can_cnt  <= 11'h000;
                end
                `SBCW_OP_SLEW: begin
                  // Code 3 fastest edges, code 0 slowest
                  slew <= rx_sh[`SBCW_SLEW_HI:`SBCW_SLEW_LO];
                end
                `SBCW_OP_STOP: begin
                  mode     <= MODE_STOP;
                  stop_arm <= 1'b0;
                end
                default: begin
                end
              endcase
            end
          end
          MODE_STOP: begin
            // The stop frame's own select release must not wake
            if (cs_fall) begin
              stop_arm <= 1'b1;
            end
            if (cs_rise && stop_arm) begin
              mode   <= MODE_WAKE;
              wk_cnt <= 14'h0000;
            end else if (stop_wake) begin
              mode    <= MODE_RUN;
              int_n   <= 1'b0;
              int_cnt <= 11'h000;
            end
          end
          MODE_WAKE: begin
            // Commands here are dropped, host must wait it out
            if (wk_cnt == CSWAKE_CYC - 14'h0001) begin
              mode <= MODE_RUN;
            end
            wk_cnt <= wk_cnt + 14'h0001;
          end
          default: begin
            mode <= MODE_RST;
          end
        endcase
      end
    end
  end

endmodule // sbcw_top

// ### verif/sbcw_props.sv
// Purpose: Port checks for sbcw_top
// Assumes: One ref_clk domain
// Notes:   Reset, chip select wake and deglitch counts follow the bound parameters
`timescale 1ns/1ps
module sbcw_props #(
  parameter int SHORT_RST  = 0,
  parameter int CSWAKE_CYC = 40,
  parameter int RST_CYC    = 100,
  parameter int RSTS_CYC   = 50,
  parameter int OC_CYC     = 30
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       mosi,
  input wire logic       miso,
  input wire logic       miso_oe,
  input wire logic       vdd_ok,
  input wire logic       vdd_oc,
  input wire logic       wake_input_0,
  input wire logic       wake_input_1,
  input wire logic       wake_input_2,
  input wire logic       wake_input_3,
  input wire logic       rst_n,
  input wire logic       int_n,
  input wire logic [1:0] mode,
  input wire logic       can_normal,
  input wire logic [1:0] slew
);
  localparam int RL = SHORT_RST ? RSTS_CYC : RST_CYC;
  localparam int RH = RL + 8;
  localparam int CL = CSWAKE_CYC - 2;
  localparam int CH = CSWAKE_CYC + 6;
  localparam int OL = OC_CYC - 2;
  localparam int OH = OC_CYC + 6;
  int         okc;
  int         lowc;
  int         fc;
  int         wfc;
  logic       sd;
  logic       cd;
  logic       arm;
  logic [3:0] wprev;
  wire  logic [3:0] wins = {wake_input_3, wake_input_2, wake_input_1,
                            wake_input_0};
  // ****
  // Helpers
  // ****
  // Raw pin edges, so sync lag lands inside the bounds
  always_ff @(posedge ref_clk) begin
    okc   <= (!nrst || !vdd_ok) ? 0 : okc + 1;
    lowc  <= int_n ? 0 : lowc + 1;
    sd    <= sclk;
    fc    <= (sd && !sclk) ? 0 : fc + 1;
    cd    <= cs_n;
    arm   <= (mode == 2'h2) && (arm || (cd && !cs_n));
    wprev <= wins;
    wfc   <= (wprev != wins) ? 0 : wfc + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_wake;
    mode == 2'h3 ##[CL:CH] mode == 2'h1;
  endsequence
  // ****
  // Checks
  // ****
  a_cs_wake: assert property (
    arm && $rose(cs_n) |-> ##[1:4] s_wake)
    else $error("chip select wake timing");
  a_int_width: assert property (
    $rose(int_n) |-> lowc == 2000)
    else $error("interrupt pulse width");
  a_int_mode: assert property (
    $fell(int_n) |-> ##[0:2] mode == 2'h1)
    else $error("interrupt without wake");
  a_wake_filt: assert property (
    $fell(int_n) && !vdd_oc |-> wfc >= 3996 && wfc <= 4008)
    else $error("wake filter time");
  a_oc_wake: assert property (
    mode == 2'h2 && $rose(vdd_oc) |-> ##[OL:OH] mode == 2'h1)
    else $error("overcurrent deglitch");
  a_can_late: assert property (
    $changed(can_normal) |-> fc < 2000)
    else $error("transceiver mode late");
  a_slew_src: assert property (
    $changed(slew) |-> fc < 16)
    else $error("slew change without frame");
  a_rst_len: assert property (
    $rose(rst_n) |-> okc >= RL && okc <= RH)
    else $error("reset duration");
  a_vdd_drop: assert property (
    !vdd_ok [*4] |-> !rst_n && mode == 2'h0)
    else $error("reset not on supply loss");
  a_sel_oe: assert property (
    $fell(cs_n) |-> ##[1:4] miso_oe)
    else $error("output not enabled");
  a_desel_oe: assert property (
    cs_n [*4] |-> !miso_oe)
    else $error("output driven while deselected");
endmodule // sbcw_props

// ### verif/sbcw_host.sv
// Purpose: Host side of the serial port
// Assumes: Serial clock idles low between frames
// Notes:   Idle data line shows the inverse of its last bit
`timescale 1ns/1ps
module sbcw_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ****
  // Frames
  // ****
  // Offset keeps pin edges off the ref_clk edges
  task automatic xfer(input logic [7:0] tx, input int hp,
                      output logic [7:0] rx);
    #0.7 cs_n = 1'b0;
    #(hp);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      #(hp / 2);
      mosi = tx[i]; // Late change, fall sampling only
      #(hp / 2);
      rx[i] = miso;
      sclk = 1'b0;
      #(hp);
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #25000;
  endtask
  task automatic cs_wake();
    #0.7 cs_n = 1'b0;
    #100 cs_n = 1'b1;
    #90000;
  endtask
endmodule // sbcw_host

// ### verif/sbcw_top_bench.sv
// Purpose: Self-checking bench for sbcw_top
// Assumes: 200 MHz ref_clk, 64 ns serial clock after a first 400 ns frame
// Notes:   Long counts cut down by parameter
`timescale 1ns/1ps
module sbcw_top_bench;
  localparam logic [13:0] CW = 14'h28;
  localparam logic [21:0] RC = 22'h64;
  localparam logic [13:0] OC = 14'h1e;
  logic       ref_clk, nrst, sclk, cs_n, mosi, miso, miso_oe;
  logic       vdd_ok, vdd_oc, rst_n, int_n, can_normal;
  logic [3:0] wk;
  logic [1:0] mode, slew;
  logic [7:0] rx;
  int         fails, samples_checked, m, c, s, r, i;
  sbcw_top #(.CSWAKE_CYC(CW), .RST_CYC(RC), .RSTS_CYC(22'h32),
    .OC_CYC(OC)) uut (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .vdd_ok(vdd_ok), .vdd_oc(vdd_oc), .wake_input_0(wk[0]),
    .wake_input_1(wk[1]), .wake_input_2(wk[2]), .wake_input_3(wk[3]),
    .rst_n(rst_n), .int_n(int_n), .mode(mode),
    .can_normal(can_normal), .slew(slew));
  sbcw_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ****
  // Tasks
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_pin();
    samples_checked++;
    if ({mode, can_normal, slew, rst_n, int_n} !==
        {m[1:0], c[0], s[1:0], m != 0, i[0]}) begin
      fails++;
      $display("CHECK FAILED t=%0t pins differ", $time);
    end
  endtask
  task automatic cmd(input logic [7:0] tx, input int hp);
    host.xfer(tx, hp, rx);
    samples_checked++;
    if (rx !== {m[1:0], c[0], s[1:0], m != 0, 1'b0, |wk}) begin
      fails++;
      $display("CHECK FAILED t=%0t status %h", $time, rx);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Frames dominate: eleven at about 26 us each, plus the waits
  initial begin
    #500000;
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'hda59e86d));
    {nrst, vdd_ok, vdd_oc, wk} = 7'h00;
    {fails, samples_checked, m, c, s, i} = {32'd0, 32'd0, 32'd0, 32'd0,
      32'd3, 32'd1};
    step(20);
    nrst = 1'b1;
    step(3);
    vdd_ok = 1'b1;
    step(RC - 6);
    chk_pin();
    step(20);
    m = 1;
    chk_pin();
    cmd(8'h00, 200);
    cmd(8'h10, 32);
    c = 1;
    chk_pin();
    r = $urandom % 4;
    for (int k = 0; k < 4; k++) begin
      cmd({6'h0c, 2'(k ^ r)}, 32);
      s = k ^ r;
      chk_pin();
    end
    cmd(8'h20, 32);
    c = 0;
    chk_pin();
    cmd(8'h40, 32);
    m = 2;
    chk_pin();
    step(1);
    wk[r] = 1'b1;
    step(4020);
    m = 1;
    i = 0;
    chk_pin();
    wk = 4'h0;
    step(2100);
    i = 1;
    #20000;
    cmd(8'h40, 32);
    m = 2;
    chk_pin();
    host.cs_wake();
    m = 1;
    chk_pin();
    cmd(8'h40, 32);
    step(1);
    vdd_oc = 1'b1;
    step(OC + 10);
    vdd_oc = 1'b0;
    i = 0;
    chk_pin();
    step(2100);
    i = 1;
    #20000;
    cmd(8'h00, 32);
    step(1);
    vdd_ok = 1'b0;
    step(8);
    m = 0;
    chk_pin();
    conclude();
  end
endmodule // sbcw_top_bench

bind sbcw_top sbcw_props #(.SHORT_RST(SHORT_RST), .CSWAKE_CYC(CSWAKE_CYC),
  .RST_CYC(RST_CYC), .RSTS_CYC(RSTS_CYC), .OC_CYC(OC_CYC)) chk (
  .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
  .miso(miso), .miso_oe(miso_oe), .vdd_ok(vdd_ok), .vdd_oc(vdd_oc),
  .wake_input_0(wake_input_0), .wake_input_1(wake_input_1),
  .wake_input_2(wake_input_2), .wake_input_3(wake_input_3),
  .rst_n(rst_n), .int_n(int_n), .mode(mode), .can_normal(can_normal),
  .slew(slew));
